// *** design/multi_function_timer_defs.vh ***
`ifndef MULTI_FUNCTION_TIMER_DEFS_VH
`define MULTI_FUNCTION_TIMER_DEFS_VH
// Register byte offsets
`define OFS_MODE_CTRL   12'h000
`define OFS_CLK_SEL     12'h004
`define OFS_PRESCALE    12'h008
`define OFS_CNT_ONE     12'h00C
`define OFS_CNT_TWO     12'h010
`define OFS_RELOAD_A    12'h014
`define OFS_RELOAD_B    12'h018
`define OFS_IRQ_EN      12'h01C
`define OFS_PENDING     12'h020
`define OFS_PAD_SEL     12'h024
// Mode control fields
`define MC_MODE_LO      0
`define MC_MODE_HI      2
`define MC_OUT_LEVEL    3
`define MC_PT_EN        4
`define MC_SW_TRIG_SEL  5
`define MC_SW_TRIG      6
`define MC_TIMER_EN     7
`define MC_EDGE_A       8
`define MC_EDGE_B       9
`define MC_PRESET_A     10
`define MC_PRESET_B     11
`define MC_EDGE_TRIG    12
`define MC_WIDTH        13
// Mode select values
`define MODE_PWM        3'h1
`define MODE_CAPTURE    3'h2
`define MODE_DUAL       3'h3
`define MODE_CAP_TIMER  3'h4
// Clock selector codes, counter one in [2:0], counter two in [6:4]
`define CK_NONE         3'h0
`define CK_PRESCALED    3'h1
`define CK_EXT_EVENT    3'h2
`define CK_PULSE_ACC    3'h3
`define CK_SLOW         3'h4
`define CK_ONE_LO       0
`define CK_TWO_LO       4
// Pending and enable bit positions
`define PB_A            0
`define PB_B            1
`define PB_UNDER_ONE    2
`define PB_UNDER_TWO    3
// Reset and preset values
`define RST_16          16'h0000
`define PRESET_FULL     16'hFFFF
`define PRESET_EMPTY    16'h0000
`define RST_PAD_SEL     16'h0000
`define PAD_LAST        8'h19
`endif

// *** design/multi_function_timer.v ***
`timescale 1ns/1ns
`include "multi_function_timer_defs.vh"
module multi_function_timer #(
  parameter PADS      = 26,
  parameter SLOW_CLK  = 1
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [PADS-1:0] pad_in,
  output reg         pwm_out,
  output reg         pwm_oe,
  output reg         irq_one,
  output reg         irq_two
);

////////////////////////////////////////////////////////////////////////////
function sel_tick;
  input [2:0] sel;
  input       pre;
  input       slow;
  input       ev;
  input       acc;
  begin
    case (sel)
      `CK_PRESCALED: sel_tick = pre;
      `CK_EXT_EVENT: sel_tick = ev;
      `CK_PULSE_ACC: sel_tick = acc;
      `CK_SLOW:      sel_tick = slow;
      default:       sel_tick = 1'b0;
    endcase
  end
endfunction

function edge_hit;
  input now;
  input prev;
  input rising;
  begin
    edge_hit = rising ? (now & ~prev) : (~now & prev);
  end
endfunction

////////////////////////////////////////////////////////////////////////////
reg  [`MC_WIDTH-1:0] mode_control_reg_r;
reg  [6:0]           clock_selector_reg_r;
reg  [7:0]           prescale_r;
reg  [15:0]          counter_one_r;
reg  [15:0]          counter_two_r;
reg  [15:0]          reload_capture_a_r;
reg  [15:0]          reload_capture_b_r;
reg  [3:0]           irq_en_r;
reg  [3:0]           pend_r;
reg  [15:0]          timer_pad_selector_r;
reg  [PADS-1:0]      pad_meta_r;
reg  [PADS-1:0]      pad_sync_r;
reg                  pin_first_prev_r;
reg                  pin_second_prev_r;
reg  [7:0]           pre_cnt_r;
reg                  slow_div_r;
reg                  next_from_b_r;
reg                  train_run_r;
reg  [2:0]           mode_prev_r;
reg                  pt_prev_r;

wire [2:0] mode_select_field = mode_control_reg_r[`MC_MODE_HI:`MC_MODE_LO];
wire       initial_output_level  = mode_control_reg_r[`MC_OUT_LEVEL];
wire       pulse_train_enable    = mode_control_reg_r[`MC_PT_EN];
wire       software_trigger_select = mode_control_reg_r[`MC_SW_TRIG_SEL];
wire       timer_enable_bit      = mode_control_reg_r[`MC_TIMER_EN];
wire       edge_select_a         = mode_control_reg_r[`MC_EDGE_A];
wire       edge_select_b         = mode_control_reg_r[`MC_EDGE_B];
wire       preset_output_enable_a = mode_control_reg_r[`MC_PRESET_A];
wire       preset_enable_b       = mode_control_reg_r[`MC_PRESET_B];
wire       edge_trigger_select   = mode_control_reg_r[`MC_EDGE_TRIG];
wire [2:0] ck_one = clock_selector_reg_r[`CK_ONE_LO+2:`CK_ONE_LO];
wire [2:0] ck_two = clock_selector_reg_r[`CK_TWO_LO+2:`CK_TWO_LO];

////////////////////////////////////////////////////////////////////////////
// APB access decode; one wait state so read data comes from a flop
wire       acc_phase = psel & penable;
wire       wr_do     = acc_phase & pready & pwrite;
wire [11:0] ofs      = {paddr[11:2], 2'b00};
wire       hit = (ofs == `OFS_MODE_CTRL) | (ofs == `OFS_CLK_SEL) |
                 (ofs == `OFS_PRESCALE) | (ofs == `OFS_CNT_ONE) |
                 (ofs == `OFS_CNT_TWO) | (ofs == `OFS_RELOAD_A) |
                 (ofs == `OFS_RELOAD_B) | (ofs == `OFS_IRQ_EN) |
                 (ofs == `OFS_PENDING) | (ofs == `OFS_PAD_SEL);
wire       wr_mc  = wr_do & (ofs == `OFS_MODE_CTRL);
wire       wr_c1  = wr_do & (ofs == `OFS_CNT_ONE);
wire       wr_c2  = wr_do & (ofs == `OFS_CNT_TWO);
wire       wr_ra  = wr_do & (ofs == `OFS_RELOAD_A);
wire       wr_rb  = wr_do & (ofs == `OFS_RELOAD_B);
wire       wr_pnd = wr_do & (ofs == `OFS_PENDING);

reg [31:0] rd_mux;
always @*
begin
  case (ofs)
    `OFS_MODE_CTRL: rd_mux = {{(32-`MC_WIDTH){1'b0}}, mode_control_reg_r};
    `OFS_CLK_SEL:   rd_mux = {25'h000_0000, clock_selector_reg_r};
    `OFS_PRESCALE:  rd_mux = {24'h00_0000, prescale_r};
    `OFS_CNT_ONE:   rd_mux = {16'h0000, counter_one_r};
    `OFS_CNT_TWO:   rd_mux = {16'h0000, counter_two_r};
    `OFS_RELOAD_A:  rd_mux = {16'h0000, reload_capture_a_r};
    `OFS_RELOAD_B:  rd_mux = {16'h0000, reload_capture_b_r};
    `OFS_IRQ_EN:    rd_mux = {28'h000_0000, irq_en_r};
    `OFS_PENDING:   rd_mux = {28'h000_0000, pend_r};
    `OFS_PAD_SEL:   rd_mux = {16'h0000, timer_pad_selector_r};
    default:        rd_mux = 32'h0000_0000;
  endcase
end

always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    pready  <= 1'b0;
    prdata  <= 32'h0000_0000;
    pslverr <= 1'b0;
  end
  else
  begin
    pready  <= acc_phase & ~pready;
    prdata  <= (acc_phase & ~pready & ~pwrite) ? rd_mux : 32'h0000_0000;
    pslverr <= acc_phase & ~pready & ~hit;
  end
end

////////////////////////////////////////////////////////////////////////////
// pad select
// Pads are asynchronous, so both selectors read the second sync stage
always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    pad_meta_r <= {PADS{1'b0}};
    pad_sync_r <= {PADS{1'b0}};
  end
  else
  begin
    pad_meta_r <= pad_in;
    pad_sync_r <= pad_meta_r;
  end
end

wire [7:0] sel_a = timer_pad_selector_r[7:0];
wire [7:0] sel_b = timer_pad_selector_r[15:8];
// Codes past the last pad read as low
wire pin_first  = (sel_a <= `PAD_LAST) ? pad_sync_r[sel_a[4:0]] : 1'b0;
wire pin_second = (sel_b <= `PAD_LAST) ? pad_sync_r[sel_b[4:0]] : 1'b0;

wire edge_a = edge_hit(pin_first, pin_first_prev_r, edge_select_a);
wire edge_b = edge_hit(pin_second, pin_second_prev_r, edge_select_b);

////////////////////////////////////////////////////////////////////////////
// prescaler
// Divides by value plus one
wire pre_tick  = timer_enable_bit & (pre_cnt_r == prescale_r);
// slow clock
// Half rate tick, absent when no fast system clock
wire slow_tick = timer_enable_bit & (SLOW_CLK != 0) & slow_div_r;
wire ev_tick   = timer_enable_bit & edge_b;
wire acc_tick  = pre_tick & pin_second;

wire is_pwm   = (mode_select_field == `MODE_PWM);
wire is_train = is_pwm & pulse_train_enable;
wire is_cap   = (mode_select_field == `MODE_CAPTURE);

// event clocks stop counter one in capture mode
wire c1_evsrc = (ck_one == `CK_EXT_EVENT) | (ck_one == `CK_PULSE_ACC);
wire c1_raw   = sel_tick(ck_one, pre_tick, slow_tick, ev_tick, acc_tick);
wire c1_tick  = c1_raw & ~(is_cap & c1_evsrc) & (~is_train | train_run_r);
wire c2_tick  = sel_tick(ck_two, pre_tick, slow_tick, ev_tick, acc_tick);

wire c1_under = c1_tick & (counter_one_r == 16'h0000);
// train steps counter two once per pulse period
wire c2_step  = is_train ? (c1_under & next_from_b_r) : c2_tick;
wire c2_under = c2_step & (counter_two_r == 16'h0000);

wire restart = (ck_one == `CK_NONE) | (is_pwm & (mode_prev_r != `MODE_PWM))
             | (is_train & ~pt_prev_r);

// train start
// Software trigger counts only once the timer is enabled
wire sw_trig = wr_mc & pwdata[`MC_SW_TRIG] & timer_enable_bit;
wire start   = is_train & ~train_run_r &
               (software_trigger_select ? sw_trig
                                        : (~edge_trigger_select & ev_tick));

wire cap_a = is_cap & timer_enable_bit & edge_a;
wire cap_b = is_cap & timer_enable_bit & edge_b;

////////////////////////////////////////////////////////////////////////////
always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    mode_control_reg_r   <= {`MC_WIDTH{1'b0}};
    clock_selector_reg_r <= 7'h00;
    prescale_r           <= 8'h00;
    irq_en_r             <= 4'h0;
    timer_pad_selector_r <= `RST_PAD_SEL;
    pin_first_prev_r     <= 1'b0;
    pin_second_prev_r    <= 1'b0;
    pre_cnt_r            <= 8'h00;
    slow_div_r           <= 1'b0;
    mode_prev_r          <= 3'h0;
    pt_prev_r            <= 1'b0;
  end
  else
  begin
    pin_first_prev_r  <= pin_first;
    pin_second_prev_r <= pin_second;
    pre_cnt_r  <= (!timer_enable_bit | pre_tick) ? 8'h00 : pre_cnt_r + 8'h01;
    slow_div_r <= timer_enable_bit & ~slow_div_r;
    mode_prev_r <= mode_select_field;
    pt_prev_r   <= is_train;
    if (wr_mc)
      // Trigger bit self-clears; it only raises a start pulse
      mode_control_reg_r <= pwdata[`MC_WIDTH-1:0] &
                            ~({{(`MC_WIDTH-1){1'b0}}, 1'b1} << `MC_SW_TRIG);
    if (wr_do & (ofs == `OFS_CLK_SEL))
      clock_selector_reg_r <= pwdata[6:0];
    if (wr_do & (ofs == `OFS_PRESCALE))
      prescale_r <= pwdata[7:0];
    if (wr_do & (ofs == `OFS_IRQ_EN))
      irq_en_r <= pwdata[3:0];
    if (wr_do & (ofs == `OFS_PAD_SEL))
      timer_pad_selector_r <= pwdata[15:0];
  end
end

////////////////////////////////////////////////////////////////////////////
// counters and reload/capture registers
always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    counter_one_r      <= `RST_16;
    counter_two_r      <= `RST_16;
    reload_capture_a_r <= `RST_16;
    reload_capture_b_r <= `RST_16;
    next_from_b_r      <= 1'b0;
    train_run_r        <= 1'b0;
    pwm_out            <= 1'b0;
    pwm_oe             <= 1'b0;
  end
  else
  begin
    pwm_oe <= is_pwm & preset_output_enable_a;
    // output level
    // Level is loaded while stopped so the first toggle starts from it
    if (~timer_enable_bit | (ck_one == `CK_NONE) | ~is_pwm |
        (is_train & ~train_run_r))
      pwm_out <= initial_output_level;
    else if (c1_under)
      pwm_out <= ~pwm_out;

    if (restart)
      next_from_b_r <= 1'b0;
    else if (is_pwm & c1_under)
      next_from_b_r <= ~next_from_b_r;

    if (~is_train)
      train_run_r <= 1'b0;
    else if (start)
      train_run_r <= 1'b1;
    else if (c2_under)
      train_run_r <= 1'b0;

    // Counter one: software write wins over hardware
    if (wr_c1)
      counter_one_r <= pwdata[15:0];
    else if (is_pwm & c1_under)
      counter_one_r <= next_from_b_r ? reload_capture_b_r
                                     : reload_capture_a_r;
    else if ((cap_a & preset_output_enable_a) | (cap_b & preset_enable_b))
      counter_one_r <= `PRESET_FULL;
    else if (c1_tick)
      counter_one_r <= counter_one_r - 16'h0001;

    if (wr_c2)
      counter_two_r <= pwdata[15:0];
    else if (c2_under & is_train)
      counter_two_r <= `PRESET_EMPTY;
    else if (c2_step)
      counter_two_r <= counter_two_r - 16'h0001;

    if (cap_a)
      reload_capture_a_r <= counter_one_r;
    else if (wr_ra)
      reload_capture_a_r <= pwdata[15:0];
    if (cap_b)
      reload_capture_b_r <= counter_one_r;
    else if (wr_rb)
      reload_capture_b_r <= pwdata[15:0];
  end
end

////////////////////////////////////////////////////////////////////////////
// pending flags
wire [3:0] set_pnd;
assign set_pnd[`PB_A] = (is_pwm & c1_under & ~next_from_b_r) | cap_a;
assign set_pnd[`PB_B] = (is_pwm & c1_under & next_from_b_r) | cap_b;
assign set_pnd[`PB_UNDER_ONE] = is_cap & c1_under;
assign set_pnd[`PB_UNDER_TWO] = c2_under;

// Write one clears; a set in the same cycle wins
wire [3:0] clr_pnd = wr_pnd ? pwdata[3:0] : 4'h0;
wire [3:0] pnd_nxt = set_pnd | (pend_r & ~clr_pnd);

always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    pend_r  <= 4'h0;
    irq_one <= 1'b0;
    irq_two <= 1'b0;
  end
  else
  begin
    pend_r  <= pnd_nxt;
    // Enables gate flags onto the two timer interrupts
    irq_one <= |(pnd_nxt[2:0] & irq_en_r[2:0]);
    irq_two <= pnd_nxt[`PB_UNDER_TWO] & irq_en_r[`PB_UNDER_TWO];
  end
end

endmodule

// *** test/mft_monitor.sv ***
`timescale 1ns/1ns
module multi_function_timer_monitor (
  input wire        clk,
  input wire        rst_n,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        irq_one,
  input wire        irq_two
);
  wire wr_done;
  assign wr_done = psel && penable && pready && pwrite;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  a_ready_latency: assert property (s_setup |-> ##2 s_done)
    else $error("pready not in second access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_rdata_idle: assert property (!(pready && !pwrite) |-> prdata == 0)
    else $error("read data outside read answer");
  a_unmapped_err: assert property (s_done ##0 paddr[11:2] > 10'd9
    |-> pslverr)
    else $error("unmapped offset without error");
  a_mapped_ok: assert property (pready && paddr[11:2] <= 10'd9
    |-> !pslverr)
    else $error("mapped offset flagged as error");
  // Flags are sticky, only software can drop an interrupt
  a_irq_one_sticky: assert property ($fell(irq_one)
    |-> $past(wr_done) || $past(wr_done, 2))
    else $error("irq_one dropped without a write");
  a_irq_two_sticky: assert property ($fell(irq_two)
    |-> $past(wr_done) || $past(wr_done, 2))
    else $error("irq_two dropped without a write");
endmodule

// *** test/pad_model.sv ***
`timescale 1ns/1ns
module pad_model (
  input  wire         clk,
  input  wire         lvl_a,
  input  wire         lvl_b,
  input  wire  [7:0]  sel_a,
  input  wire  [7:0]  sel_b,
  output logic [25:0] pad_in
);
  initial pad_in = 26'h155_5555;
  // levels change only on clock edges, held whole cycles
  // Unused pads flip every cycle so a wrong pad choice shows
  always @(posedge clk)
  begin
    pad_in <= ~pad_in;
    pad_in[sel_a] <= lvl_a;
    pad_in[sel_b] <= lvl_b;
  end
endmodule

// *** test/tb_multi_function_timer.sv ***
`timescale 1ns/1ns
`include "multi_function_timer_defs.vh"
module tb_multi_function_timer;
  localparam [31:0] EN  = 32'h1 << `MC_TIMER_EN;
  localparam [31:0] AEN = 32'h1 << `MC_PRESET_A;
  localparam [31:0] PT  = 32'h1 << `MC_PT_EN;
  localparam [31:0] SWS = 32'h1 << `MC_SW_TRIG_SEL;
  localparam [31:0] SWT = 32'h1 << `MC_SW_TRIG;
  logic        clk, rst_n, psel, penable, pwrite, lvl_a, lvl_b, pwm_d;
  logic        pready, pslverr, pwm_out, pwm_oe, irq_one, irq_two;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [25:0] pad_in;
  logic [7:0]  sel_a, sel_b;
  logic [15:0] ra, rb, v;
  integer      seed, errors, n_compared, i;
  integer      cyc = 0;
  integer      tgl = 0;

  multi_function_timer i_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
    .pwm_out(pwm_out), .pwm_oe(pwm_oe), .irq_one(irq_one),
    .irq_two(irq_two));
  pad_model i_pads (.clk(clk), .lvl_a(lvl_a), .lvl_b(lvl_b),
    .sel_a(sel_a), .sel_b(sel_b), .pad_in(pad_in));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    pwm_d <= pwm_out;
    if (pwm_out !== pwm_d)
      tgl <= tgl + 1;
    if (cyc == 60000)
    begin
      errors = errors + 1;
      end_sim;
    end
  end

  // Slow source ticks every second clock, so each span doubles
  function automatic integer exp_span(input logic [15:0] r,
                                      input logic slow);
    return (slow ? 2 : 1) * (r + 1);
  endfunction
  function automatic integer exp_tgl(input integer n);
    return 2 * (n + 1);
  endfunction

  task automatic end_sim;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd_v = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (e !== g)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                     input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd_v);
  endtask

  // Cycles until the next output toggle is seen
  task automatic span(output integer n);
    integer t0;
    t0 = tgl;
    n = 0;
    while (tgl == t0)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic pwm_run(input logic lvl);
    integer d1, d2;
    ra = 16'd2 + 16'($random(seed) & 7);
    rb = 16'd2 + 16'($random(seed) & 7);
    // Stop first: the restart must take its first reload from A
    apb(1'b1, `OFS_CLK_SEL, 32'h0);
    apb(1'b1, `OFS_PRESCALE, 32'h0);
    apb(1'b1, `OFS_RELOAD_A, {16'h0, ra});
    apb(1'b1, `OFS_RELOAD_B, {16'h0, rb});
    apb(1'b1, `OFS_CNT_ONE, 32'h3);
    apb(1'b1, `OFS_CNT_TWO, 32'h5);
    apb(1'b1, `OFS_IRQ_EN, 32'h9);
    // Old flags cleared so this run must set them again
    apb(1'b1, `OFS_PENDING, 32'hF);
    apb(1'b1, `OFS_MODE_CTRL, `MODE_PWM | EN | AEN
        | (32'(lvl) << `MC_OUT_LEVEL));
    // Second run clocks counter one from the slow source
    apb(1'b1, `OFS_CLK_SEL, lvl ? 32'h14 : 32'h11);
    span(d1);
    span(d1);
    span(d2);
    chk("span_a", exp_span(ra, lvl), d1);
    chk("span_b", exp_span(rb, lvl), d2);
    chk("pwm_level", {31'h0, ~lvl}, {31'h0, pwm_out});
    chk("pwm_oe", 32'h1, {31'h0, pwm_oe});
    apb(1'b0, `OFS_PENDING, 32'h0);
    chk("pend_pwm", 32'hB, rd_v & 32'hB);
    chk("irq_pwm", 32'h3, {30'h0, irq_one, irq_two});
    apb(1'b1, `OFS_CLK_SEL, 32'h0);
  endtask

  task automatic train(input logic edge_start);
    integer t0, n;
    n = $random(seed) & 3;
    apb(1'b1, `OFS_CNT_TWO, n);
    apb(1'b1, `OFS_CNT_ONE, 32'h2);
    apb(1'b1, `OFS_PENDING, 32'hF);
    apb(1'b1, `OFS_MODE_CTRL, `MODE_PWM | PT | EN | AEN
        | (edge_start ? 32'h0 : SWS));
    apb(1'b1, `OFS_CLK_SEL, 32'h1);
    t0 = tgl;
    // start by pin edge or by the trigger bit after enable
    if (edge_start)
      lvl_b <= 1'b0;
    else
      apb(1'b1, `OFS_MODE_CTRL, `MODE_PWM | PT | EN | AEN | SWS | SWT);
    repeat (300) @(posedge clk);
    chk("pulses", exp_tgl(n), tgl - t0);
    rdc(`OFS_CNT_TWO, 32'h0, "cnt_two_end");
    apb(1'b0, `OFS_PENDING, 32'h0);
    chk("pend_train", 32'h8, rd_v & 32'h8);
    apb(1'b1, `OFS_CLK_SEL, 32'h0);
  endtask

  task automatic capture;
    v = 16'($random(seed));
    apb(1'b1, `OFS_CLK_SEL, `CK_EXT_EVENT);
    apb(1'b1, `OFS_RELOAD_B, 32'h0);
    apb(1'b1, `OFS_PENDING, 32'hF);
    apb(1'b1, `OFS_IRQ_EN, 32'h3);
    apb(1'b1, `OFS_CNT_ONE, {16'h0, v});
    apb(1'b1, `OFS_MODE_CTRL, `MODE_CAPTURE | EN | AEN
        | (32'h1 << `MC_EDGE_A));
    lvl_b <= 1'b1;
    @(posedge clk);
    lvl_a <= 1'b1;
    repeat (8) @(posedge clk);
    rdc(`OFS_RELOAD_A, {16'h0, v}, "cap_a");
    rdc(`OFS_RELOAD_B, 32'h0, "cap_b_rise");
    rdc(`OFS_CNT_ONE, 32'hFFFF, "preset_a");
    lvl_b <= 1'b0;
    repeat (8) @(posedge clk);
    rdc(`OFS_RELOAD_B, 32'hFFFF, "cap_b");
    apb(1'b0, `OFS_PENDING, 32'h0);
    chk("pend_cap", 32'h3, rd_v & 32'h3);
    chk("irq_cap", 32'h1, {31'h0, irq_one});
    apb(1'b1, `OFS_PENDING, 32'h3);
    repeat (3) @(posedge clk);
    chk("irq_clr", 32'h0, {31'h0, irq_one});
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 23;
    errors = 0;
    n_compared = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    lvl_a = 1'b0;
    lvl_b = 1'b1;
    sel_a = 8'($random(seed) & 7);
    sel_b = sel_a + 8'h12;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // Last index is unmapped and must read zero
    for (i = 0; i < 11; i++)
      rdc(12'(4 * i), 32'h0, "reset_val");
    v = 16'($random(seed));
    apb(1'b1, `OFS_CNT_ONE, {16'h0, v});
    rdc(`OFS_CNT_ONE, {16'h0, v}, "cnt_one");
    apb(1'b1, `OFS_PAD_SEL, {16'h0, sel_b, sel_a});
    rdc(`OFS_PAD_SEL, {16'h0, sel_b, sel_a}, "pad_sel");
    pwm_run(1'b0);
    pwm_run(1'b1);
    train(1'b0);
    train(1'b1);
    capture;
    end_sim;
  end
endmodule

bind multi_function_timer multi_function_timer_monitor i_mon (
  .clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq_one(irq_one), .irq_two(irq_two));
